// ==== bsf_consts.svh ====
`ifndef BSF_CONSTS_SVH
`define BSF_CONSTS_SVH

// bus geometry
`define BSF_ADDR_W      8
`define BSF_DATA_W      32
`define BSF_STRB_W      4

// register byte offsets
`define BSF_OFF_CMD     8'h00
`define BSF_OFF_OPERAND 8'h04
`define BSF_OFF_STATUS  8'h08
`define BSF_OFF_STACK   8'h0C
`define BSF_OFF_IO_BASE 8'h40
`define BSF_OFF_IO_LAST 8'h7C

// command word field positions
`define BSF_CMD_OP_LSB  0
`define BSF_CMD_OP_W    5
`define BSF_CMD_BIT_LSB 8
`define BSF_CMD_BIT_W   3
`define BSF_CMD_IO_LSB  16

// storage sizes
`define BSF_IO_DEPTH    16
`define BSF_IO_IDX_W    4
`define BSF_STACK_DEPTH 16
`define BSF_SP_W        5
`define BSF_STACK_FULL  5'h10
`define BSF_SP_ONE      5'h01

// status register bit positions
`define BSF_FLAG_C      0
`define BSF_FLAG_Z      1
`define BSF_FLAG_N      2
`define BSF_FLAG_V      3
`define BSF_FLAG_T      6

// stack info register fields
`define BSF_INFO_OVF    8
`define BSF_INFO_UNF    9
`define BSF_INFO_BADOP  10

// reset values and responses
`define BSF_BYTE_RST    8'h00
`define BSF_WORD_RST    32'h00000000
`define BSF_RESP_OKAY   2'h0
`define BSF_RESP_SLVERR 2'h2

`endif

// ==== bsf_pkg.sv ====
`default_nettype none
`include "bsf_consts.svh"

package bsf_pkg;

	// operation codes, numbered in declaration order from zero
	typedef enum logic [`BSF_CMD_OP_W-1:0] {
		bsf_op_nop,
		bsf_op_stack_push,
		bsf_op_stack_pop,
		bsf_op_io_bit_set,
		bsf_op_io_bit_clear,
		bsf_op_logical_shift_left,
		bsf_op_logical_shift_right,
		bsf_op_rotate_left_through_carry,
		bsf_op_rotate_right_through_carry,
		bsf_op_arithmetic_shift_right,
		bsf_op_nibble_exchange,
		bsf_op_indexed_flag_clear,
		bsf_op_bit_to_transfer_flag,
		bsf_op_transfer_flag_to_bit,
		bsf_op_carry_flag_on,
		bsf_op_carry_flag_off,
		bsf_op_negative_flag_on,
		bsf_op_negative_flag_off,
		bsf_op_zero_flag_on
	} bsf_op_t;

	// register regions seen by the bus decoder
	typedef enum logic [2:0] {
		bsf_reg_cmd,
		bsf_reg_operand,
		bsf_reg_status,
		bsf_reg_stack,
		bsf_reg_io,
		bsf_reg_none
	} bsf_region_t;

	// one command as written by software
	typedef struct packed {
		logic [`BSF_IO_IDX_W-1:0]  io_addr;
		logic [`BSF_CMD_BIT_W-1:0] bit_sel;
		logic [`BSF_CMD_OP_W-1:0]  opcode;
	} bsf_cmd_t;

	// flags produced by the shift unit
	typedef struct packed {
		logic c;
		logic z;
		logic n;
		logic v;
	} bsf_shift_flags_t;

endpackage
`default_nettype wire

// ==== bsf_shift_unit.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "bsf_consts.svh"

module bsf_shift_unit (
	input  wire logic                     carry_in,
	input  wire bsf_pkg::bsf_op_t         op,
	input  wire logic [7:0]               value,
	output logic [7:0]                    result,
	output bsf_pkg::bsf_shift_flags_t     flags
);

	// shift and rotate result, carry out taken from the bit that leaves
	always_comb begin
		result  = value;
		flags.c = carry_in;
		case (op)
			bsf_pkg::bsf_op_logical_shift_left: begin
				result  = {value[6:0], 1'b0};
				flags.c = value[7];
			end
			bsf_pkg::bsf_op_logical_shift_right: begin
				result  = {1'b0, value[7:1]};
				flags.c = value[0];
			end
			bsf_pkg::bsf_op_rotate_left_through_carry: begin
				result  = {value[6:0], carry_in};
				flags.c = value[7];
			end
			bsf_pkg::bsf_op_rotate_right_through_carry: begin
				result  = {carry_in, value[7:1]};
				flags.c = value[0];
			end
			bsf_pkg::bsf_op_arithmetic_shift_right: begin
				result  = {value[7], value[7:1]};
				flags.c = value[0];
			end
			default: begin
				result  = value;
				flags.c = carry_in;
			end
		endcase
		// overflow is sign xor carry, the usual rule for one-place shifts
		flags.z = (result == `BSF_BYTE_RST);
		flags.n = result[7];
		flags.v = result[7] ^ flags.c;
	end

endmodule
`default_nettype wire

// ==== bsf_datapath.sv ====
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "bsf_consts.svh"

// Summary of operation
// - push copies operand onto stack, flags untouched
// - pop loads operand from stack, flags untouched
// - io bit set forces chosen bit one
// - io bit clear forces chosen bit zero
// - shift left, zero in, update Z C N V
// - shift right, zero in, update Z C N V
// - rotate left through carry, update Z C N V
// - rotate right through carry, update Z C N V
// - arithmetic right keeps sign, update Z C N V
// - swap nibbles, flags untouched
// - indexed flag clear zeroes one status bit
// - bit store copies chosen bit into T
// - bit load copies T into chosen bit
// - carry on sets C, carry off clears C
// - negative on sets N, off clears N
// - zero on sets Z only
module bsf_datapath (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [`BSF_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [`BSF_DATA_W-1:0] s_axi_wdata,
	input  wire logic [`BSF_STRB_W-1:0] s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [`BSF_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [`BSF_DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	output logic [7:0]                  status_flags
);

	// map a byte address to the register it hits
	function automatic bsf_pkg::bsf_region_t decode(input logic [`BSF_ADDR_W-1:0] addr);
		bsf_pkg::bsf_region_t r;
		r = bsf_pkg::bsf_reg_none;
		if (addr[1:0] == 2'h0) begin
			if (addr == `BSF_OFF_CMD)
				r = bsf_pkg::bsf_reg_cmd;
			else if (addr == `BSF_OFF_OPERAND)
				r = bsf_pkg::bsf_reg_operand;
			else if (addr == `BSF_OFF_STATUS)
				r = bsf_pkg::bsf_reg_status;
			else if (addr == `BSF_OFF_STACK)
				r = bsf_pkg::bsf_reg_stack;
			else if (addr >= `BSF_OFF_IO_BASE && addr <= `BSF_OFF_IO_LAST)
				r = bsf_pkg::bsf_reg_io;
		end
		return r;
	endfunction

	// word index of an io register inside its window
	function automatic logic [`BSF_IO_IDX_W-1:0] io_index(input logic [`BSF_ADDR_W-1:0] addr);
		return addr[`BSF_IO_IDX_W+1:2];
	endfunction

	// held write channels and the stored state
	logic [`BSF_ADDR_W-1:0]   aw_addr_q;
	logic [`BSF_DATA_W-1:0]   w_data_q;
	logic [`BSF_STRB_W-1:0]   w_strb_q;
	logic [7:0]               operand;
	logic [7:0]               io_mem [`BSF_IO_DEPTH];
	logic [7:0]               stack_mem [`BSF_STACK_DEPTH];
	logic [`BSF_SP_W-1:0]     stack_ptr;
	logic                     err_overflow;
	logic                     err_underflow;
	logic                     err_badop;
	bsf_pkg::bsf_cmd_t        last_cmd;

	// decoded write and the command it may carry
	logic                     write_fire;
	bsf_pkg::bsf_region_t     wr_region;
	bsf_pkg::bsf_region_t     rd_region;
	logic                     exec_go;
	bsf_pkg::bsf_cmd_t        wr_cmd;
	bsf_pkg::bsf_op_t         wr_op;
	logic [7:0]               shift_result;
	bsf_pkg::bsf_shift_flags_t shift_flags;

	// next values from one executed command
	logic [7:0]               next_operand;
	logic [7:0]               next_status;
	logic [`BSF_SP_W-1:0]     next_stack_ptr;
	logic                     stack_we;
	logic                     io_we;
	logic [7:0]               io_value;
	logic                     set_overflow;
	logic                     set_underflow;
	logic                     set_badop;
	logic [`BSF_DATA_W-1:0]   rd_word;

	// both halves of a write are held before it acts, so the order they arrive in is free
	assign write_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_region  = decode(aw_addr_q);
	assign rd_region  = decode(s_axi_araddr);
	assign exec_go    = write_fire && wr_region == bsf_pkg::bsf_reg_cmd && w_strb_q[0];
	assign wr_cmd     = {w_data_q[`BSF_CMD_IO_LSB +: `BSF_IO_IDX_W],
	                     w_data_q[`BSF_CMD_BIT_LSB +: `BSF_CMD_BIT_W],
	                     w_data_q[`BSF_CMD_OP_LSB +: `BSF_CMD_OP_W]};
	assign wr_op      = bsf_pkg::bsf_op_t'(wr_cmd.opcode);

	bsf_shift_unit bsf_shift_unit_i (
		.carry_in (status_flags[`BSF_FLAG_C]),
		.op       (wr_op),
		.value    (operand),
		.result   (shift_result),
		.flags    (shift_flags)
	);

	// effect of one command; flags not named by an operation keep their value
	always_comb begin
		next_operand   = operand;
		next_status    = status_flags;
		next_stack_ptr = stack_ptr;
		stack_we       = 1'b0;
		io_we          = 1'b0;
		io_value       = io_mem[wr_cmd.io_addr];
		set_overflow   = 1'b0;
		set_underflow  = 1'b0;
		set_badop      = 1'b0;
		case (wr_op)
			bsf_pkg::bsf_op_nop: begin
				next_operand = operand;
			end
			bsf_pkg::bsf_op_stack_push: begin
				// a full stack refuses the push rather than overwrite the oldest entry
				if (stack_ptr == `BSF_STACK_FULL) begin
					set_overflow = 1'b1;
				end else begin
					stack_we       = 1'b1;
					next_stack_ptr = stack_ptr + `BSF_SP_ONE;
				end
			end
			bsf_pkg::bsf_op_stack_pop: begin
				if (stack_ptr == `BSF_SP_W'(0)) begin
					set_underflow = 1'b1;
				end else begin
					next_operand   = stack_mem[stack_ptr[3:0] - 4'h1];
					next_stack_ptr = stack_ptr - `BSF_SP_ONE;
				end
			end
			bsf_pkg::bsf_op_io_bit_set: begin
				io_we                    = 1'b1;
				io_value[wr_cmd.bit_sel] = 1'b1;
			end
			bsf_pkg::bsf_op_io_bit_clear: begin
				io_we                    = 1'b1;
				io_value[wr_cmd.bit_sel] = 1'b0;
			end
			bsf_pkg::bsf_op_logical_shift_left,
			bsf_pkg::bsf_op_logical_shift_right,
			bsf_pkg::bsf_op_rotate_left_through_carry,
			bsf_pkg::bsf_op_rotate_right_through_carry,
			bsf_pkg::bsf_op_arithmetic_shift_right: begin
				next_operand              = shift_result;
				next_status[`BSF_FLAG_C]  = shift_flags.c;
				next_status[`BSF_FLAG_Z]  = shift_flags.z;
				next_status[`BSF_FLAG_N]  = shift_flags.n;
				next_status[`BSF_FLAG_V]  = shift_flags.v;
			end
			bsf_pkg::bsf_op_nibble_exchange: begin
				next_operand = {operand[3:0], operand[7:4]};
			end
			bsf_pkg::bsf_op_indexed_flag_clear: begin
				next_status[wr_cmd.bit_sel] = 1'b0;
			end
			bsf_pkg::bsf_op_bit_to_transfer_flag: begin
				next_status[`BSF_FLAG_T] = operand[wr_cmd.bit_sel];
			end
			bsf_pkg::bsf_op_transfer_flag_to_bit: begin
				next_operand[wr_cmd.bit_sel] = status_flags[`BSF_FLAG_T];
			end
			bsf_pkg::bsf_op_carry_flag_on: begin
				next_status[`BSF_FLAG_C] = 1'b1;
			end
			bsf_pkg::bsf_op_carry_flag_off: begin
				next_status[`BSF_FLAG_C] = 1'b0;
			end
			bsf_pkg::bsf_op_negative_flag_on: begin
				next_status[`BSF_FLAG_N] = 1'b1;
			end
			bsf_pkg::bsf_op_negative_flag_off: begin
				next_status[`BSF_FLAG_N] = 1'b0;
			end
			bsf_pkg::bsf_op_zero_flag_on: begin
				next_status[`BSF_FLAG_Z] = 1'b1;
			end
			default: begin
				set_badop = 1'b1;
			end
		endcase
	end

	// write address channel: ready again only once the response has gone
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			aw_addr_q     <= `BSF_ADDR_W'(0);
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_addr_q     <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	// write data channel, held alongside the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b1;
			w_data_q     <= `BSF_WORD_RST;
			w_strb_q     <= `BSF_STRB_W'(0);
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_data_q     <= s_axi_wdata;
			w_strb_q     <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	// write response, error for an address outside the map
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `BSF_RESP_OKAY;
		end else if (write_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wr_region == bsf_pkg::bsf_reg_none) ? `BSF_RESP_SLVERR
			                                                      : `BSF_RESP_OKAY;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// operand register: software load or command result
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			operand <= `BSF_BYTE_RST;
		end else if (exec_go) begin
			operand <= next_operand;
		end else if (write_fire && wr_region == bsf_pkg::bsf_reg_operand && w_strb_q[0]) begin
			operand <= w_data_q[7:0];
		end
	end

	// status register drives the flag output directly
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_flags <= `BSF_BYTE_RST;
		end else if (exec_go) begin
			status_flags <= next_status;
		end else if (write_fire && wr_region == bsf_pkg::bsf_reg_status && w_strb_q[0]) begin
			status_flags <= w_data_q[7:0];
		end
	end

	// last command, kept for readback
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_cmd <= '0;
		end else if (exec_go) begin
			last_cmd <= wr_cmd;
		end
	end

	// io registers: whole-byte writes from the bus, single-bit edits by command
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < `BSF_IO_DEPTH; i++) begin
				io_mem[i] <= `BSF_BYTE_RST;
			end
		end else if (exec_go && io_we) begin
			io_mem[wr_cmd.io_addr] <= io_value;
		end else if (write_fire && wr_region == bsf_pkg::bsf_reg_io && w_strb_q[0]) begin
			io_mem[io_index(aw_addr_q)] <= w_data_q[7:0];
		end
	end

	// stack storage needs no reset; only pushed entries are ever read back
	always_ff @(posedge aclk) begin
		if (exec_go && stack_we) begin
			stack_mem[stack_ptr[3:0]] <= operand;
		end
	end

	// stack pointer counts entries held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stack_ptr <= `BSF_SP_W'(0);
		end else if (exec_go) begin
			stack_ptr <= next_stack_ptr;
		end
	end

	// sticky errors, cleared by writing one; a new error wins over the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_overflow  <= 1'b0;
			err_underflow <= 1'b0;
			err_badop     <= 1'b0;
		end else if (exec_go) begin
			err_overflow  <= err_overflow | set_overflow;
			err_underflow <= err_underflow | set_underflow;
			err_badop     <= err_badop | set_badop;
		end else if (write_fire && wr_region == bsf_pkg::bsf_reg_stack && w_strb_q[1]) begin
			err_overflow  <= err_overflow & ~w_data_q[`BSF_INFO_OVF];
			err_underflow <= err_underflow & ~w_data_q[`BSF_INFO_UNF];
			err_badop     <= err_badop & ~w_data_q[`BSF_INFO_BADOP];
		end
	end

	// read data multiplexer
	always_comb begin
		rd_word = `BSF_WORD_RST;
		case (rd_region)
			bsf_pkg::bsf_reg_cmd: begin
				rd_word[`BSF_CMD_OP_LSB +: `BSF_CMD_OP_W]  = last_cmd.opcode;
				rd_word[`BSF_CMD_BIT_LSB +: `BSF_CMD_BIT_W] = last_cmd.bit_sel;
				rd_word[`BSF_CMD_IO_LSB +: `BSF_IO_IDX_W]   = last_cmd.io_addr;
			end
			bsf_pkg::bsf_reg_operand: begin
				rd_word[7:0] = operand;
			end
			bsf_pkg::bsf_reg_status: begin
				rd_word[7:0] = status_flags;
			end
			bsf_pkg::bsf_reg_stack: begin
				rd_word[`BSF_SP_W-1:0]     = stack_ptr;
				rd_word[`BSF_INFO_OVF]     = err_overflow;
				rd_word[`BSF_INFO_UNF]     = err_underflow;
				rd_word[`BSF_INFO_BADOP]   = err_badop;
			end
			bsf_pkg::bsf_reg_io: begin
				rd_word[7:0] = io_mem[io_index(s_axi_araddr)];
			end
			default: begin
				rd_word = `BSF_WORD_RST;
			end
		endcase
	end

	// read channel: one read in flight, data sampled when the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= `BSF_WORD_RST;
			s_axi_rresp   <= `BSF_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= (rd_region == bsf_pkg::bsf_reg_none) ? `BSF_RESP_SLVERR
			                                                       : `BSF_RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ==== bsf_datapath_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "bsf_consts.svh"
// protocol and flag-timing watch on the datapath's own ports
module bsf_datapath_sva (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [7:0]  status_flags
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// a write takes both halves, stays quiet one cycle, then answers
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wr_quiet;
		!s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	endsequence
	a_write_answer: assert property (s_wr_taken |=> s_wr_quiet ##1 s_axi_bvalid)
		else $error("write answer not on time");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	a_b_release: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not released");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready) else $error("read answer not on time");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer dropped");
	a_r_release: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid && s_axi_arready) else $error("read not released");
	// flags only move at the edge that raises the write answer
	a_flags_at_resp: assert property ($past(aresetn) && $changed(status_flags) |->
		$rose(s_axi_bvalid)) else $error("flags moved outside a command");
	a_no_second_aw: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready) else $error("second write accepted");
	// a command taken whole at one edge acts at the edge that raises the answer
	sequence s_cmd(logic [`BSF_CMD_OP_W-1:0] code);
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0]
			&& s_axi_awaddr == `BSF_OFF_CMD
			&& s_axi_wdata[`BSF_CMD_OP_LSB +: `BSF_CMD_OP_W] == code;
	endsequence
	a_carry_on_set: assert property (s_cmd(bsf_pkg::bsf_op_carry_flag_on) |=>
		##1 status_flags[`BSF_FLAG_C]) else $error("carry not set by command");
	a_zero_on_set: assert property (s_cmd(bsf_pkg::bsf_op_zero_flag_on) |=>
		##1 status_flags[`BSF_FLAG_Z]) else $error("zero flag not set by command");
endmodule
bind bsf_datapath bsf_datapath_sva bsf_datapath_sva_i (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awaddr, .s_axi_wdata, .s_axi_wstrb,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.status_flags);
`default_nettype wire

// ==== bsf_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// stands in for the core decoder: one register-bus transfer per call
module bsf_host_model (
	input  wire logic        aclk,
	output logic [7:0]       s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [7:0]       s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	// bus idles at time zero
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
	end
	// decisions sampled at the falling edge, so they never race the slave's flops;
	// a released payload shows its inverse rather than the last value
	task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
		output bit to);
		logic ta, tw;
		logic tb = 1'b0;
		@(posedge aclk);
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_awaddr, s_axi_wdata} <= {3'h7, a, d};
		repeat (40) begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			{tb, r} = {s_axi_bvalid, s_axi_bresp};
			@(posedge aclk);
			if (ta) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
			if (tw) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
			if (tb) s_axi_bready <= 1'b0;
			if (tb) break;
		end
		to = ~tb;
	endtask
	task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
		output bit to);
		logic ta;
		logic tr = 1'b0;
		@(posedge aclk);
		{s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'h3, a};
		repeat (40) begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			{tr, d, r} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge aclk);
			if (ta) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
			if (tr) s_axi_rready <= 1'b0;
			if (tr) break;
		end
		to = ~tr;
	endtask
endmodule
`default_nettype wire

// ==== bsf_datapath_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module bsf_datapath_test;
	logic        aclk;
	logic        aresetn;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, status_flags;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          num_errors = 0;
	int          total_checks = 0;
	bsf_datapath bsf_datapath_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .status_flags);
	bsf_host_model bsf_host_model_i (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	// 25 MHz core clock
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// a bus wait that used up its bound counts as a mismatch and ends the run
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		bit         to;
		bsf_host_model_i.write(a, d, r, to);
		num_errors += to;
		if (to) end_sim();
		chk({30'h0, r}, {30'h0, er});
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		bit          to;
		bsf_host_model_i.read(a, d, r, to);
		num_errors += to;
		if (to) end_sim();
		chk(d, e);
		chk({30'h0, r}, {30'h0, er});
	endtask
	// command word: opcode, bit select and io index in their fields
	task automatic op(input int c, input int b, input int io);
		wr(8'h00, {12'h000, io[3:0], 5'h00, b[2:0], 3'h0, c[4:0]}, 2'h0);
	endtask
	task automatic prep(input logic [7:0] st, input logic [7:0] v);
		wr(8'h08, {24'h0, st}, 2'h0);
		wr(8'h04, {24'h0, v}, 2'h0);
	endtask
	task automatic fl(input logic [7:0] e);
		chk({24'h0, status_flags}, {24'h0, e});
	endtask
	// reset values, unmapped place and an unknown opcode
	task automatic t_bus();
		rdc(8'h08, 32'h0, 2'h0);
		rdc(8'h0C, 32'h0, 2'h0);
		rdc(8'h10, 32'h0, 2'h2);
		wr(8'h10, 32'h1, 2'h2);
		op(19, 0, 0);
		rdc(8'h0C, 32'h400, 2'h0);
		wr(8'h0C, 32'h400, 2'h0);
	endtask
	// every shift kind, both carry values, a zero result among them; T must survive
	task automatic t_shift();
		logic [7:0] v, res;
		logic       c, co;
		for (int o = 5; o <= 9; o++) begin
			for (int k = 0; k < 2; k++) begin
				v = k ? 8'h80 : 8'h01;
				c = k[0];
				case (o)
					5: {co, res} = {v, 1'b0};
					6: {res, co} = {1'b0, v};
					7: {co, res} = {v, c};
					8: {res, co} = {c, v};
					default: {res, co} = {v[7], v};
				endcase
				prep({7'h20, c}, v);
				op(o, 0, 0);
				rdc(8'h04, {24'h0, res}, 2'h0);
				fl({4'h4, res[7] ^ co, res[7], res == 8'h00, co});
			end
		end
	endtask
	task automatic t_flags();
		int         ops[5] = '{14, 18, 16, 15, 17};
		logic [7:0] ex[5] = '{8'h01, 8'h03, 8'h07, 8'h06, 8'h02};
		prep(8'h00, 8'h00);
		for (int i = 0; i < 5; i++) begin
			op(ops[i], 0, 0);
			fl(ex[i]);
		end
		op(11, 1, 0);
		fl(8'h00);
		prep(8'hFF, 8'h00);
		op(11, 6, 0);
		fl(8'hBF);
	endtask
	// nibble swap, then T stored from a set and a clear bit, then a T set by a status write loaded into a bit
	task automatic t_bits();
		prep(8'h4F, 8'hA5);
		op(10, 0, 0);
		rdc(8'h04, 32'h5A, 2'h0);
		fl(8'h4F);
		prep(8'h00, 8'h08);
		op(12, 3, 0);
		fl(8'h40);
		op(12, 2, 0);
		fl(8'h00);
		prep(8'h40, 8'h00);
		op(13, 5, 0);
		rdc(8'h04, 32'h20, 2'h0);
		fl(8'h40);
	endtask
	// neighbour io register must not move
	task automatic t_io();
		wr(8'h50, 32'hFF, 2'h0);
		wr(8'h4C, 32'h00, 2'h0);
		prep(8'h0F, 8'h00);
		op(3, 7, 3);
		op(3, 0, 3);
		rdc(8'h4C, 32'h81, 2'h0);
		op(4, 7, 3);
		rdc(8'h4C, 32'h01, 2'h0);
		rdc(8'h50, 32'hFF, 2'h0);
		fl(8'h0F);
	endtask
	// last in first out, then pop on empty and push on full
	task automatic t_stack();
		prep(8'h0F, 8'h11);
		op(1, 0, 0);
		wr(8'h04, 32'h22, 2'h0);
		op(1, 0, 0);
		wr(8'h04, 32'h00, 2'h0);
		rdc(8'h0C, 32'h2, 2'h0);
		op(2, 0, 0);
		rdc(8'h04, 32'h22, 2'h0);
		op(2, 0, 0);
		rdc(8'h04, 32'h11, 2'h0);
		fl(8'h0F);
		op(2, 0, 0);
		rdc(8'h0C, 32'h200, 2'h0);
		wr(8'h0C, 32'h200, 2'h0);
		for (int i = 0; i < 17; i++)
			op(1, 0, 0);
		rdc(8'h0C, 32'h110, 2'h0);
	endtask
	// reset for 5 cycles, then every scenario in turn
	initial begin
		aresetn = 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_bus();
		t_shift();
		t_flags();
		t_bits();
		t_io();
		t_stack();
		end_sim();
	end
endmodule
`default_nettype wire
